// [design/ims_irq_ctrl.sv]
// Operation
// - one read-write enable bit per channel, bits 10 to 0, passes request.
// - cleared enable blocks request from both outputs and status; resets to zero.
// - per-channel software request bit acts like an asserted hardware input.
// - software request stays until software writes zero to it.
// - software request bits for all eleven channels; upper bits reserved.
// - channel map: 1,6,7,8,9 active low, the rest active high.
// - four-bit nibble: low three bits select event, top bit routes to fast.
// - events latch into pending even when disabled; write one clears.
// - pending OR software request before masking; software never stored.
// - outputs gated by global control bits 0 and 1.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module ims_irq_ctrl
   import ims_pkg::*;
#(
   parameter int NCH = IMS_NCH
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // request sources
   input wire logic [7:0] chan_req_i,
   input wire logic dma_req_i,
   input wire logic ext_request0_n_i,
   input wire logic ext_request1_n_i,
   // processor interrupt lines
   output logic normal_irq_out_n_o,
   output logic fast_irq_out_n_o,
   // block interrupt
   output logic irq_o
);

   // ****************************************
   // registers
   // ****************************************
   ims_bus_st_t bus_st_r;
   ims_bus_st_t bus_st_nxt;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic [1:0] ctl_r;
   logic [1:0] ctl_nxt;
   logic [NCH-1:0] pend_r;
   logic [NCH-1:0] pend_nxt;
   logic [IMS_CFG_W*NCH-1:0] cfg_r;
   logic [IMS_CFG_W*NCH-1:0] cfg_nxt;
   logic [NCH-1:0] en_r;
   logic [NCH-1:0] en_nxt;
   logic [NCH-1:0] soft_r;
   logic [NCH-1:0] soft_nxt;
   logic [IMS_NEV-1:0] evst_r;
   logic [IMS_NEV-1:0] evst_nxt;
   logic [IMS_NEV-1:0] evmsk_r;
   logic [IMS_NEV-1:0] evmsk_nxt;
   logic nrm_n_r;
   logic nrm_n_nxt;
   logic fst_n_r;
   logic fst_n_nxt;
   logic irq_r;
   logic irq_nxt;

   // ****************************************
   // request assembly and detection
   // ****************************************
   logic [NCH-1:0] raw_req;
   logic [3*NCH-1:0] sel_vec;
   logic [NCH-1:0] hw_evt;
   logic [NCH-1:0] route_fst;
   logic [NCH-1:0] act_req;
   logic [NCH-1:0] nrm_view;
   logic [NCH-1:0] fst_view;
   logic nrm_act;
   logic fst_act;

   // sources keep their native polarity; nibbles set the sense
   assign raw_req = {dma_req_i, ext_request1_n_i, ext_request0_n_i, chan_req_i};

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_cfg
         assign sel_vec[3*g +: 3] = cfg_r[IMS_CFG_W*g +: 3];
         assign route_fst[g] = cfg_r[IMS_CFG_W*g + IMS_CFG_ROUTE];
      end
   endgenerate

   ims_evt_detect #(
      .N(NCH)
   ) u_detect (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .req_i(raw_req),
      .sel_i(sel_vec),
      .evt_o(hw_evt)
   );

   always_comb begin
      act_req = (pend_r | soft_r) & en_r;
      nrm_view = act_req & ~route_fst;
      fst_view = act_req & route_fst;
      nrm_act = ctl_r[IMS_CTL_NRM_ON] & (|nrm_view);
      fst_act = ctl_r[IMS_CTL_FST_ON] & (|fst_view);
   end

   // ****************************************
   // bus decode
   // ****************************************
   logic req;
   logic wr;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] cfg1_rd;
   logic [31:0] cfg2_rd;

   always_comb begin
      req = wb_cyc_i & wb_stb_i & (bus_st_r == IMS_BUS_IDLE);
      wr = req & wb_we_i;
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wbits = wb_dat_i & wmask;
      cfg1_rd = cfg_r[IMS_CFG_W*IMS_CFG1_NCH-1:0];
      cfg2_rd = {20'h00000, cfg_r[IMS_CFG_W*NCH-1:IMS_CFG_W*IMS_CFG1_NCH]};
   end

   // ****************************************
   // bus handshake and read data
   // ****************************************
   always_comb begin
      bus_st_nxt = bus_st_r;
      rdat_nxt = rdat_r;
      case (bus_st_r)
         IMS_BUS_IDLE: begin
            if (req) begin
               bus_st_nxt = IMS_BUS_ACK;
               rdat_nxt = 32'h0000_0000;
               if (!wb_we_i) begin
                  case (wb_adr_i)
                     IMS_ADR_CONTROL: rdat_nxt = {30'h0000_0000, ctl_r};
                     IMS_ADR_NRM_STAT: rdat_nxt = {21'h00_0000, nrm_view};
                     IMS_ADR_FST_STAT: rdat_nxt = {21'h00_0000, fst_view};
                     IMS_ADR_PENDING: rdat_nxt = {21'h00_0000, pend_r};
                     IMS_ADR_CONFIG_1: rdat_nxt = cfg1_rd;
                     IMS_ADR_CONFIG_2: rdat_nxt = cfg2_rd;
                     IMS_ADR_REQ_MASK: rdat_nxt = {21'h00_0000, en_r};
                     IMS_ADR_SOFT_REQ: rdat_nxt = {21'h00_0000, soft_r};
                     IMS_ADR_EV_STAT: rdat_nxt = {30'h0000_0000, evst_r};
                     IMS_ADR_EV_MASK: rdat_nxt = {30'h0000_0000, evmsk_r};
                     default: rdat_nxt = 32'h0000_0000;
                  endcase
               end
            end
         end
         IMS_BUS_ACK: begin
            bus_st_nxt = IMS_BUS_IDLE;
         end
         default: begin
            bus_st_nxt = IMS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_st_r <= IMS_BUS_IDLE;
         rdat_r <= 32'h0000_0000;
      end else begin
         bus_st_r <= bus_st_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   always_comb begin
      ctl_nxt = ctl_r;
      cfg_nxt = cfg_r;
      en_nxt = en_r;
      soft_nxt = soft_r;
      evmsk_nxt = evmsk_r;
      if (wr) begin
         case (wb_adr_i)
            IMS_ADR_CONTROL: ctl_nxt = (ctl_r & ~wmask[1:0]) | wbits[1:0];
            IMS_ADR_CONFIG_1: begin
               cfg_nxt[IMS_CFG_W*IMS_CFG1_NCH-1:0] = (cfg1_rd & ~wmask) | wbits;
            end
            IMS_ADR_CONFIG_2: begin
               cfg_nxt[IMS_CFG_W*NCH-1:IMS_CFG_W*IMS_CFG1_NCH] = (cfg2_rd[11:0] & ~wmask[11:0]) | wbits[11:0];
            end
            IMS_ADR_REQ_MASK: en_nxt = (en_r & ~wmask[NCH-1:0]) | wbits[NCH-1:0];
            IMS_ADR_SOFT_REQ: soft_nxt = (soft_r & ~wmask[NCH-1:0]) | wbits[NCH-1:0];
            IMS_ADR_EV_MASK: evmsk_nxt = (evmsk_r & ~wmask[1:0]) | wbits[1:0];
            default: ctl_nxt = ctl_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_r <= IMS_RST_CONTROL;
         cfg_r <= {IMS_RST_CONFIG_2, IMS_RST_CONFIG_1};
         en_r <= IMS_RST_REQ_MASK;
         soft_r <= IMS_RST_SOFT_REQ;
         evmsk_r <= IMS_RST_EV;
      end else begin
         ctl_r <= ctl_nxt;
         cfg_r <= cfg_nxt;
         en_r <= en_nxt;
         soft_r <= soft_nxt;
         evmsk_r <= evmsk_nxt;
      end
   end

   // ****************************************
   // pending store
   // ****************************************
   logic [NCH-1:0] pend_clr;

   always_comb begin
      pend_clr = '0;
      if (wr && (wb_adr_i == IMS_ADR_PENDING)) begin
         pend_clr = wbits[NCH-1:0];
      end
      // new event wins over a clear; enable does not gate the store
      pend_nxt = (pend_r & ~pend_clr) | hw_evt;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_r <= IMS_RST_PENDING;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // ****************************************
   // processor lines and block interrupt
   // ****************************************
   logic [IMS_NEV-1:0] ev_set;
   logic [IMS_NEV-1:0] ev_clr;

   always_comb begin
      nrm_n_nxt = ~nrm_act;
      fst_n_nxt = ~fst_act;
      ev_set = '0;
      ev_set[IMS_EV_NRM] = nrm_act & nrm_n_r;
      ev_set[IMS_EV_FST] = fst_act & fst_n_r;
      ev_clr = '0;
      if (wr && (wb_adr_i == IMS_ADR_EV_STAT)) begin
         ev_clr = wbits[IMS_NEV-1:0];
      end
      evst_nxt = (evst_r & ~ev_clr) | ev_set;
      irq_nxt = |(evst_nxt & evmsk_nxt);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nrm_n_r <= 1'b1;
         fst_n_r <= 1'b1;
         evst_r <= IMS_RST_EV;
         irq_r <= 1'b0;
      end else begin
         nrm_n_r <= nrm_n_nxt;
         fst_n_r <= fst_n_nxt;
         evst_r <= evst_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign wb_ack_o = (bus_st_r == IMS_BUS_ACK);
   assign wb_dat_o = rdat_r;
   assign normal_irq_out_n_o = nrm_n_r;
   assign fast_irq_out_n_o = fst_n_r;
   assign irq_o = irq_r;

endmodule

`default_nettype wire

// [inc/ims_pkg.sv]
package ims_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int IMS_NCH = 11;
   localparam int IMS_NEV = 2;

   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [31:0] IMS_ADR_CONTROL = 32'h3000_0000;
   localparam logic [31:0] IMS_ADR_NRM_STAT = 32'h3000_0004;
   localparam logic [31:0] IMS_ADR_FST_STAT = 32'h3000_0008;
   localparam logic [31:0] IMS_ADR_PENDING = 32'h3000_000C;
   localparam logic [31:0] IMS_ADR_CONFIG_1 = 32'h3000_0010;
   localparam logic [31:0] IMS_ADR_CONFIG_2 = 32'h3000_0014;
   localparam logic [31:0] IMS_ADR_REQ_MASK = 32'h3000_0020;
   localparam logic [31:0] IMS_ADR_SOFT_REQ = 32'h3000_0030;
   localparam logic [31:0] IMS_ADR_EV_STAT = 32'h3000_0040;
   localparam logic [31:0] IMS_ADR_EV_MASK = 32'h3000_0044;

   // ****************************************
   // field positions
   // ****************************************
   localparam int IMS_CTL_NRM_ON = 0;
   localparam int IMS_CTL_FST_ON = 1;
   localparam int IMS_CFG_ROUTE = 3;
   localparam int IMS_CFG_LEVEL = 2;
   localparam int IMS_CFG_HIGH = 0;
   localparam int IMS_CFG_W = 4;
   localparam int IMS_CFG1_NCH = 8;
   localparam int IMS_EV_NRM = 0;
   localparam int IMS_EV_FST = 1;

   // ****************************************
   // event select codes
   // ****************************************
   localparam logic [2:0] IMS_SEL_OFF = 3'h0;
   localparam logic [2:0] IMS_SEL_FALL = 3'h1;
   localparam logic [2:0] IMS_SEL_RISE = 3'h2;
   localparam logic [2:0] IMS_SEL_BOTH = 3'h3;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [1:0] IMS_RST_CONTROL = 2'h0;
   localparam logic [10:0] IMS_RST_PENDING = 11'h000;
   localparam logic [31:0] IMS_RST_CONFIG_1 = 32'h0000_0000;
   localparam logic [11:0] IMS_RST_CONFIG_2 = 12'h000;
   localparam logic [10:0] IMS_RST_REQ_MASK = 11'h000;
   localparam logic [10:0] IMS_RST_SOFT_REQ = 11'h000;
   localparam logic [1:0] IMS_RST_EV = 2'h0;

   // ****************************************
   // bus slave state
   // ****************************************
   typedef enum logic [0:0] {
      IMS_BUS_IDLE = 1'b0,
      IMS_BUS_ACK = 1'b1
   } ims_bus_st_t;

endpackage

// [design/ims_evt_detect.sv]
`timescale 1ns/100ps
`default_nettype none

module ims_evt_detect
   import ims_pkg::*;
#(
   parameter int N = IMS_NCH
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // requests and selection
   input wire logic [N-1:0] req_i,
   input wire logic [3*N-1:0] sel_i,
   // recognised events
   output logic [N-1:0] evt_o
);

   // ****************************************
   // previous level per channel
   // ****************************************
   logic [N-1:0] prev_r;
   logic [N-1:0] prev_nxt;

   always_comb begin
      prev_nxt = req_i;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_r <= '0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   // ****************************************
   // event decode per channel
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic [2:0] sel;
         logic rise;
         logic fall;
         assign sel = sel_i[3*g +: 3];
         assign rise = req_i[g] & ~prev_r[g];
         assign fall = ~req_i[g] & prev_r[g];
         always_comb begin
            if (sel[IMS_CFG_LEVEL]) begin
               evt_o[g] = (req_i[g] == sel[IMS_CFG_HIGH]);
            end else begin
               case (sel)
                  IMS_SEL_FALL: evt_o[g] = fall;
                  IMS_SEL_RISE: evt_o[g] = rise;
                  IMS_SEL_BOTH: evt_o[g] = rise | fall;
                  default: evt_o[g] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// [tb/ims_irq_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module ims_irq_ctrl_chk
   import ims_pkg::*;
#(
   parameter int NCH = IMS_NCH
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // sources and lines
   input wire logic [7:0] chan_req_i,
   input wire logic dma_req_i,
   input wire logic ext_request0_n_i,
   input wire logic ext_request1_n_i,
   input wire logic normal_irq_out_n_o,
   input wire logic fast_irq_out_n_o,
   input wire logic irq_o
);
   // ****************************************
   // bus and line checks
   // ****************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   logic tk;
   logic wr;
   assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = tk & wb_we_i;
   a_ack_follows: assert property (tk |=> wb_ack_o) else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(tk)) else $error("ack unasked");
   a_reset_idle: assert property ($rose(rst_n_i) |-> normal_irq_out_n_o && fast_irq_out_n_o && !irq_o)
      else $error("lines not idle");
   a_mask_blocks: assert property (wr && wb_adr_i == IMS_ADR_REQ_MASK && wb_sel_i[1:0] == 2'h3
      && wb_dat_i[10:0] == 11'h000 |-> ##2 normal_irq_out_n_o && fast_irq_out_n_o) else $error("mask leak");
   a_nrm_global: assert property (wr && wb_adr_i == IMS_ADR_CONTROL && wb_sel_i[0] && !wb_dat_i[0]
      |-> ##2 normal_irq_out_n_o) else $error("normal not gated");
   a_fst_global: assert property (wr && wb_adr_i == IMS_ADR_CONTROL && wb_sel_i[0] && !wb_dat_i[1]
      |-> ##2 fast_irq_out_n_o) else $error("fast not gated");
   a_rsv_zero: assert property (tk && !wb_we_i && (wb_adr_i == IMS_ADR_REQ_MASK || wb_adr_i == IMS_ADR_SOFT_REQ)
      |=> wb_dat_o[31:NCH] == '0) else $error("reserved bits set");
   a_hole_zero: assert property (tk && !wb_we_i && wb_adr_i == 32'h3000_0018 |=> wb_dat_o == 32'h0)
      else $error("hole not zero");
endmodule
bind ims_irq_ctrl ims_irq_ctrl_chk #(.NCH(NCH)) i_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_req_i(chan_req_i),
   .dma_req_i(dma_req_i), .ext_request0_n_i(ext_request0_n_i), .ext_request1_n_i(ext_request1_n_i),
   .normal_irq_out_n_o(normal_irq_out_n_o), .fast_irq_out_n_o(fast_irq_out_n_o), .irq_o(irq_o));
`default_nettype wire

// [tb/ims_src_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ims_src_model
   import ims_pkg::*;
#(
   parameter logic [10:0] LOW_CH = 11'h3C2
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // logical requests, high asserts
   input wire logic [IMS_NCH-1:0] req_on_i,
   // raw source lines
   output logic [7:0] chan_req_o,
   output logic dma_req_o,
   output logic ext_request0_n_o,
   output logic ext_request1_n_o
);
   // ****************************************
   // source polarity
   // ****************************************
   logic [IMS_NCH-1:0] raw_r;
   logic [IMS_NCH-1:0] raw_nxt;
   always_comb begin
      raw_nxt = req_on_i ^ LOW_CH;
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         raw_r <= LOW_CH;
      end else begin
         raw_r <= raw_nxt;
      end
   end
   assign chan_req_o = raw_r[7:0];
   assign ext_request0_n_o = raw_r[8];
   assign ext_request1_n_o = raw_r[9];
   assign dma_req_o = raw_r[10];
endmodule
`default_nettype wire

// [tb/ims_irq_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module ims_irq_ctrl_tb
   import ims_pkg::*;
;
   // ****************************************
   // bench
   // ****************************************
   localparam logic [10:0] LOW_CH = 11'h3C2;
   logic clk_sys_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dma_req, ext0_n, ext1_n;
   logic nrm_n, fst_n, irq_o;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
   logic [7:0] chan_req;
   logic [10:0] req_on;
   int n_mismatch = 0;
   int tests_run = 0;
   ims_irq_ctrl i_ims_irq_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_req_i(chan_req), .dma_req_i(dma_req),
      .ext_request0_n_i(ext0_n), .ext_request1_n_i(ext1_n), .normal_irq_out_n_o(nrm_n),
      .fast_irq_out_n_o(fst_n), .irq_o(irq_o));
   ims_src_model i_ims_src_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_on_i(req_on),
      .chan_req_o(chan_req), .dma_req_o(dma_req), .ext_request0_n_o(ext0_n), .ext_request1_n_o(ext1_n));
   task report_and_stop;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         n_mismatch++;
         report_and_stop;
      end
   endtask
   task s_regs;
      bus(1'h0, IMS_ADR_REQ_MASK, 32'h0);
      check(q, 32'h0);
      bus(1'h0, IMS_ADR_SOFT_REQ, 32'h0);
      check(q, 32'h0);
      bus(1'h1, IMS_ADR_REQ_MASK, 32'hFFFF_FFFF);
      bus(1'h0, IMS_ADR_REQ_MASK, 32'h0);
      check(q, 32'h7FF);
      wb_sel_i <= 4'h2;
      bus(1'h1, IMS_ADR_REQ_MASK, 32'h0);
      wb_sel_i <= 4'hF;
      bus(1'h0, IMS_ADR_REQ_MASK, 32'h0);
      check(q, 32'h0FF);
      bus(1'h1, IMS_ADR_REQ_MASK, 32'h7FF);
      bus(1'h1, IMS_ADR_SOFT_REQ, 32'hFFFF_FFFF);
      bus(1'h0, IMS_ADR_SOFT_REQ, 32'h0);
      check(q, 32'h7FF);
      bus(1'h1, IMS_ADR_SOFT_REQ, 32'h0);
      bus(1'h0, IMS_ADR_SOFT_REQ, 32'h0);
      check(q, 32'h0);
      bus(1'h1, IMS_ADR_CONTROL, 32'hFFFF_FFFF);
      bus(1'h0, IMS_ADR_CONTROL, 32'h0);
      check(q, 32'h3);
      bus(1'h1, IMS_ADR_CONTROL, 32'h0);
      bus(1'h0, 32'h3000_0018, 32'h0);
      check(q, 32'h0);
   endtask
   task s_soft;
      bus(1'h1, IMS_ADR_EV_MASK, 32'h0);
      bus(1'h1, IMS_ADR_CONTROL, 32'h3);
      bus(1'h1, IMS_ADR_CONFIG_2, 32'h800);
      bus(1'h1, IMS_ADR_SOFT_REQ, 32'h8);
      tick(2);
      check({nrm_n, fst_n}, 2'h1);
      bus(1'h0, IMS_ADR_NRM_STAT, 32'h0);
      check(q, 32'h8);
      bus(1'h0, IMS_ADR_PENDING, 32'h0);
      check(q, 32'h0);
      bus(1'h0, IMS_ADR_EV_STAT, 32'h0);
      check(q, 32'h1);
      check(irq_o, 1'h0);
      bus(1'h1, IMS_ADR_EV_MASK, 32'h1);
      tick(1);
      check(irq_o, 1'h1);
      bus(1'h1, IMS_ADR_EV_STAT, 32'h1);
      tick(1);
      check(irq_o, 1'h0);
      bus(1'h1, IMS_ADR_CONTROL, 32'h2);
      tick(2);
      check(nrm_n, 1'h1);
      bus(1'h1, IMS_ADR_CONTROL, 32'h3);
      tick(2);
      check(nrm_n, 1'h0);
      bus(1'h1, IMS_ADR_REQ_MASK, 32'h7F7);
      tick(2);
      check(nrm_n, 1'h1);
      bus(1'h1, IMS_ADR_REQ_MASK, 32'h7FF);
      bus(1'h1, IMS_ADR_SOFT_REQ, 32'h400);
      tick(2);
      check({nrm_n, fst_n}, 2'h2);
      bus(1'h0, IMS_ADR_FST_STAT, 32'h0);
      check(q, 32'h400);
      bus(1'h0, IMS_ADR_NRM_STAT, 32'h0);
      check(q, 32'h0);
      bus(1'h0, IMS_ADR_EV_STAT, 32'h0);
      check(q, 32'h3);
      bus(1'h1, IMS_ADR_CONTROL, 32'h1);
      tick(2);
      check(fst_n, 1'h1);
      bus(1'h1, IMS_ADR_SOFT_REQ, 32'h0);
      bus(1'h1, IMS_ADR_CONTROL, 32'h0);
   endtask
   task s_edges;
      for (int c = 0; c < 4; c++) begin
         bus(1'h1, IMS_ADR_CONFIG_1, c);
         req_on[0] <= 1'h1;
         tick(3);
         bus(1'h0, IMS_ADR_PENDING, 32'h0);
         check(q, c[1]);
         bus(1'h1, IMS_ADR_PENDING, 32'h1);
         req_on[0] <= 1'h0;
         tick(3);
         bus(1'h0, IMS_ADR_PENDING, 32'h0);
         check(q, c[0]);
         bus(1'h1, IMS_ADR_PENDING, 32'h1);
      end
   endtask
   task s_levels;
      logic [31:0] a;
      bus(1'h1, IMS_ADR_REQ_MASK, 32'h0);
      bus(1'h1, IMS_ADR_CONTROL, 32'h1);
      for (int i = 0; i < 11; i++) begin
         a = (i < 8) ? IMS_ADR_CONFIG_1 : IMS_ADR_CONFIG_2;
         bus(1'h1, a, (LOW_CH[i] ? 32'h4 : 32'h5) << (4 * (i % 8)));
         req_on[i] <= 1'h1;
         tick(3);
         bus(1'h0, IMS_ADR_PENDING, 32'h0);
         check(q, 32'h1 << i);
         check(nrm_n, 1'h1);
         bus(1'h0, IMS_ADR_NRM_STAT, 32'h0);
         check(q, 32'h0);
         req_on[i] <= 1'h0;
         tick(3);
         bus(1'h1, IMS_ADR_PENDING, 32'h1 << i);
         bus(1'h0, IMS_ADR_PENDING, 32'h0);
         check(q, 32'h0);
         bus(1'h1, a, 32'h0);
      end
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      rst_n_i = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_sel_i = 4'hF;
      wb_adr_i = 32'h0;
      wb_dat_i = 32'h0;
      req_on = 11'h000;
      tick(20);
      rst_n_i <= 1'b1;
      s_regs;
      s_soft;
      s_edges;
      s_levels;
      report_and_stop;
   end
endmodule
`default_nettype wire
